// >>> core/tmf_flags.sv
// Match-B and counter wrap flag registers of a three-channel timer, with APB access and interrupts.
`include "tmf_cfg.svh"
module tmf_flags
  import tmf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`TMF_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire tmf_events_s i_events,
  input wire tmf_mode_s i_mode,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [`TMF_NCH-1:0] o_match_b_request,
  output logic [`TMF_NCH-1:0] o_wrap_request,
  output logic o_irq
);

  localparam logic [7:0] RESET_VAL = `TMF_RESET_VAL;
  localparam logic [7:0] RSVD_MASK = `TMF_RSVD_MASK;

  tmf_ch_t match_b_en_q;
  tmf_ch_t match_b_flag_q;
  tmf_ch_t wrap_en_q;
  tmf_ch_t wrap_flag_q;
  tmf_ch_t match_b_armed_q;
  tmf_ch_t wrap_armed_q;
  logic [`TMF_IRQ_W-1:0] irq_status_q;
  logic [`TMF_IRQ_W-1:0] irq_mask_q;
  tmf_ch_t match_b_set;
  tmf_ch_t wrap_set;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] wbyte;

  function automatic logic [7:0] pack_reg(input tmf_ch_t en, input tmf_ch_t flag);
    pack_reg = RSVD_MASK | {1'b0, en, 1'b0, flag};
  endfunction

  function automatic logic hit(input logic [`TMF_ADDR_W-1:0] a, input logic [`TMF_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  assign access = i_psel && i_penable && o_pready;
  assign wr = access && i_pwrite && i_pstrb[0];
  assign rd = access && !i_pwrite;
  assign wbyte = i_pwdata[7:0];
  assign mapped = hit(i_paddr, `TMF_OFS_MATCH_B) || hit(i_paddr, `TMF_OFS_WRAP) ||
                  hit(i_paddr, `TMF_OFS_IRQ_STATUS) || hit(i_paddr, `TMF_OFS_IRQ_MASK);

  // Capture mode picks which event source sets each match-B flag.
  genvar g;
  generate
    for (g = 0; g < `TMF_NCH; g++) begin : g_set
      assign match_b_set[g] = i_mode.capture_mode[g] ? i_events.capture[g]
                                                     : i_events.compare_match[g];
    end
  endgenerate

  // Underflow is honoured only for channel 2 in phase counting with direction select zero.
  assign wrap_set[2] = i_events.overflow[2] ||
                       (i_events.underflow && i_mode.phase_counting_select &&
                        !i_mode.wrap_direction_select);
  assign wrap_set[1] = i_events.overflow[1];
  assign wrap_set[0] = i_events.overflow[0];

  // Single-cycle access phase keeps the bus simple; no wait states are inserted while i_clk_en is high.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (i_clk_en) begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !hit(i_paddr, `TMF_OFS_MATCH_B) && !hit(i_paddr, `TMF_OFS_WRAP) &&
                   !hit(i_paddr, `TMF_OFS_IRQ_STATUS) && !hit(i_paddr, `TMF_OFS_IRQ_MASK);
      if (i_psel && !i_penable && !i_pwrite) begin
        unique case (1'b1)
          hit(i_paddr, `TMF_OFS_MATCH_B): o_prdata <= {24'h000000, pack_reg(match_b_en_q, match_b_flag_q)};
          hit(i_paddr, `TMF_OFS_WRAP): o_prdata <= {24'h000000, pack_reg(wrap_en_q, wrap_flag_q)};
          hit(i_paddr, `TMF_OFS_IRQ_STATUS): o_prdata <= {26'h0000000, irq_status_q};
          hit(i_paddr, `TMF_OFS_IRQ_MASK): o_prdata <= {26'h0000000, irq_mask_q};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Enables, reset and standby.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      match_b_en_q <= RESET_VAL[6:4];
      wrap_en_q <= RESET_VAL[6:4];
    end else if (i_clk_en) begin
      if (i_mode.standby) begin
        match_b_en_q <= RESET_VAL[6:4];
        wrap_en_q <= RESET_VAL[6:4];
      end else if (wr && hit(i_paddr, `TMF_OFS_MATCH_B)) begin
        match_b_en_q <= wbyte[6:4];
      end else if (wr && hit(i_paddr, `TMF_OFS_WRAP)) begin
        wrap_en_q <= wbyte[6:4];
      end
    end
  end

  // A read that sees a flag at one arms it for clearing by a later zero write.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      match_b_flag_q <= RESET_VAL[2:0];
      wrap_flag_q <= RESET_VAL[2:0];
      match_b_armed_q <= 3'h0;
      wrap_armed_q <= 3'h0;
    end else if (i_clk_en) begin
      if (i_mode.standby) begin
        match_b_flag_q <= RESET_VAL[2:0];
        wrap_flag_q <= RESET_VAL[2:0];
        match_b_armed_q <= 3'h0;
        wrap_armed_q <= 3'h0;
      end else begin
        if (rd && hit(i_paddr, `TMF_OFS_MATCH_B)) begin
          match_b_armed_q <= match_b_flag_q;
        end else if (wr && hit(i_paddr, `TMF_OFS_MATCH_B)) begin
          match_b_armed_q <= match_b_armed_q & wbyte[2:0];
        end
        if (rd && hit(i_paddr, `TMF_OFS_WRAP)) begin
          wrap_armed_q <= wrap_flag_q;
        end else if (wr && hit(i_paddr, `TMF_OFS_WRAP)) begin
          wrap_armed_q <= wrap_armed_q & wbyte[2:0];
        end
        if (wr && hit(i_paddr, `TMF_OFS_MATCH_B)) begin
          match_b_flag_q <= (match_b_flag_q & ~(match_b_armed_q & ~wbyte[2:0])) | match_b_set;
        end else begin
          match_b_flag_q <= match_b_flag_q | match_b_set;
        end
        if (wr && hit(i_paddr, `TMF_OFS_WRAP)) begin
          wrap_flag_q <= (wrap_flag_q & ~(wrap_armed_q & ~wbyte[2:0])) | wrap_set;
        end else begin
          wrap_flag_q <= wrap_flag_q | wrap_set;
        end
      end
    end
  end

  // Summary interrupt: sticky copy of each flag's set input, sampled every cycle without edge detection, write one to clear, set wins.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      irq_status_q <= 6'h00;
      irq_mask_q <= 6'h00;
    end else if (i_clk_en) begin
      if (wr && hit(i_paddr, `TMF_OFS_IRQ_MASK)) begin
        irq_mask_q <= wbyte[5:0];
      end
      if (wr && hit(i_paddr, `TMF_OFS_IRQ_STATUS)) begin
        irq_status_q <= (irq_status_q & ~wbyte[5:0]) | {wrap_set, match_b_set};
      end else begin
        irq_status_q <= irq_status_q | {wrap_set, match_b_set};
      end
    end
  end

  // Registered requests lag their flags by one cycle.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_match_b_request <= 3'h0;
      o_wrap_request <= 3'h0;
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_match_b_request <= match_b_flag_q & match_b_en_q;
      o_wrap_request <= wrap_flag_q & wrap_en_q;
      o_irq <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule

// >>> core/tmf_cfg.svh
// Register offsets, field positions, reset values and bus widths of the timer flag bank.
`ifndef TMF_CFG_SVH
`define TMF_CFG_SVH
`define TMF_OFS_MATCH_B 8'h00
`define TMF_OFS_WRAP 8'h04
`define TMF_OFS_IRQ_STATUS 8'h08
`define TMF_OFS_IRQ_MASK 8'h0C
`define TMF_ADDR_W 8
`define TMF_RESET_VAL 8'h88
`define TMF_RSVD_MASK 8'h88
`define TMF_EN_LSB 4
`define TMF_FLAG_LSB 0
`define TMF_NCH 3
`define TMF_IRQ_W 6
`endif

// >>> core/tmf_pkg.sv
// Types shared by the timer flag bank.
`include "tmf_cfg.svh"
package tmf_pkg;
  typedef logic [`TMF_NCH-1:0] tmf_ch_t;
  typedef struct packed {
    logic [`TMF_NCH-1:0] compare_match;
    logic [`TMF_NCH-1:0] capture;
    logic [`TMF_NCH-1:0] overflow;
    logic underflow;
  } tmf_events_s;
  typedef struct packed {
    logic [`TMF_NCH-1:0] capture_mode;
    logic phase_counting_select;
    logic wrap_direction_select;
    logic standby;
  } tmf_mode_s;
endpackage

// >>> bench/tmf_flags_props.sv
// Checker for bus answers, read-back layout and request outputs of the flag bank.
`include "tmf_cfg.svh"
module tmf_flags_props
  import tmf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`TMF_ADDR_W-1:0] i_paddr,
  input wire tmf_mode_s i_mode,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [`TMF_NCH-1:0] o_match_b_request,
  input wire logic [`TMF_NCH-1:0] o_wrap_request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready) else $error("late ready");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready held");
  a_idle_no_ready: assert property (!i_psel |=> !o_pready) else $error("ready while idle");
  a_unmapped_err: assert property (i_psel && i_penable && o_pready |->
    o_pslverr == (i_paddr > 8'h0C || i_paddr[1:0] != 2'h0)) else $error("bad error flag");
  a_err_no_data: assert property (o_pslverr |-> o_prdata == 32'h0) else $error("data on error");
  a_reserved_ones: assert property (o_pready && !i_pwrite && i_paddr[7:3] == 5'h0 && i_paddr[1:0] == 2'h0 |->
    o_prdata[31:8] == 24'h0 && o_prdata[7] && o_prdata[3]) else $error("reserved bits");
  a_match_req_gate: assert property (o_pready && !i_pwrite && i_paddr == 8'h00 |->
    o_match_b_request == (o_prdata[6:4] & o_prdata[2:0])) else $error("match request");
  a_wrap_req_gate: assert property (o_pready && !i_pwrite && i_paddr == 8'h04 |->
    o_wrap_request == (o_prdata[6:4] & o_prdata[2:0])) else $error("wrap request");
  a_standby_quiet: assert property (i_mode.standby |-> ##2 (o_match_b_request == 3'h0 && o_wrap_request == 3'h0))
    else $error("standby request");
endmodule
bind tmf_flags tmf_flags_props u_props (.i_clk_sys, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_mode, .o_prdata, .o_pready, .o_pslverr, .o_match_b_request, .o_wrap_request);

// >>> bench/tmf_cpu.sv
// Processor-side bus master model for the flag bank.
module tmf_cpu (
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_ready,
  input wire logic i_err,
  output logic o_sel,
  output logic o_en,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic err = 1'h0;
  int hung = 0;
  initial {o_sel, o_en, o_wr, o_addr, o_wdata} = '0;
  // The request stays put until ready is sampled or 16 edges pass; a slower answer is counted as hung and its data taken anyway.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k = 0;
    @(posedge i_clk);
    {o_sel, o_en, o_wr, o_addr, o_wdata} <= {2'h2, w, a, d};
    @(posedge i_clk);
    o_en <= 1'h1;
    do @(posedge i_clk); while (i_ready !== 1'h1 && ++k < 16);
    hung += int'(k >= 16);
    q = i_rdata;
    err = i_err;
    {o_sel, o_en} <= 2'h0;
  endtask
endmodule

// >>> bench/tmf_flags_test.sv
// Register-level test of the flag bank through its bus and event inputs.
module tmf_flags_test
  import tmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] mreq, wreq;
  tmf_events_s ev = '0;
  tmf_mode_s md = '0;
  int err_total = 0;
  int num_checks = 0;
  initial forever #50 clk = ~clk;
  tmf_flags dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(1'h1), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .i_events(ev), .i_mode(md),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_match_b_request(mreq),
    .o_wrap_request(wreq), .o_irq(irq));
  tmf_cpu cpu (.i_clk(clk), .i_rdata(prdata), .i_ready(pready), .i_err(pslverr), .o_sel(psel),
    .o_en(penable), .o_wr(pwrite), .o_addr(paddr), .o_wdata(pwdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    err_total += cpu.hung;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cpu.xfer(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic pulse(input tmf_events_s e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    rd(8'h00, 32'h88);
    rd(8'h04, 32'h88);
    rd(8'h10, 32'h0);
    chk(cpu.err, 1'h1);
    wr(8'h00, 32'hFF);
    rd(8'h00, 32'hF8);
    md <= 6'h10;
    pulse(10'h080);
    pulse(10'h020);
    rd(8'h00, 32'hFB);
    wr(8'h00, 32'hFA);
    rd(8'h00, 32'hFA);
    chk(mreq, 3'h2);
    wr(8'h00, 32'hFA);
    rd(8'h00, 32'hFA);
    wr(8'h00, 32'hF8);
    rd(8'h00, 32'hF8);
    wr(8'h00, 32'h8A);
    rd(8'h00, 32'h88);
    chk(mreq, 3'h0);
    $display("match flags done");
    md <= 6'h00;
    pulse(10'h001);
    md <= 6'h06;
    pulse(10'h001);
    rd(8'h04, 32'h88);
    md <= 6'h04;
    pulse(10'h001);
    rd(8'h04, 32'h8C);
    pulse(10'h004);
    pulse(10'h002);
    rd(8'h04, 32'h8F);
    wr(8'h04, 32'hFE);
    rd(8'h04, 32'hFE);
    chk(wreq, 3'h6);
    $display("wrap flags done");
    chk(irq, 1'h0);
    wr(8'h0C, 32'h3F);
    rd(8'h08, 32'h3B);
    chk(irq, 1'h1);
    wr(8'h08, 32'h3B);
    rd(8'h08, 32'h0);
    chk(irq, 1'h0);
    $display("interrupt done");
    md <= 6'h01;
    @(posedge clk);
    md <= 6'h00;
    rd(8'h00, 32'h88);
    rd(8'h04, 32'h88);
    $display("standby done");
    end_sim;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    end_sim;
  end
endmodule
